/* hw/odo_pkg.sv */
// Constants shared by the odometer front end and its pin counter.
// Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus.
package odo_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 8;
	localparam int TIME_MS_NS = 1000000;
	localparam int CYCLES_PER_MS = TIME_MS_NS / CLK_PERIOD_NS;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ROLL = 8'h04;
	localparam logic [7:0] OFS_RATE = 8'h08;
	localparam logic [7:0] OFS_LAT = 8'h0c;
	localparam logic [7:0] OFS_QUANT = 8'h10;
	localparam logic [7:0] OFS_SCALE = 8'h14;
	localparam logic [7:0] OFS_HWPER = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1c;
	localparam logic [7:0] OFS_HWCNT = 8'h20;
	localparam logic [7:0] OFS_ESTMAX = 8'h24;
	localparam logic [7:0] OFS_MEASINT = 8'h28;
	localparam logic [7:0] OFS_CLEAR = 8'h2c;
	// Control field positions
	localparam int TICK_PIN_ENABLE = 0;
	localparam int DIRECTION_POLARITY_AUTO_OFF = 1;
	localparam int DIRECTION_POLARITY_SELECT = 2;
	localparam int DUAL_EDGE_COUNT_ENABLE = 3;
	localparam int MESSAGE_SOURCE_AUTO_OFF = 4;
	localparam int REAR_WHEEL_MERGE_ENABLE = 5;
	localparam int ROLLOVER_ESTIMATE_OFF = 6;
	localparam int SPEED_INPUT_SELECT = 7;
	localparam int SPEED_AUTO_SELECT_OFF = 8;
	localparam int TIME_MARK_MODE = 9;
	localparam int CTRL_W = 10;
	// Reset values
	localparam logic [9:0] CTRL_RST = 10'h000;
	localparam logic [31:0] HWPER_RST = 32'h0000_0064;
	// Measurement data types
	localparam logic [5:0] TYPE_REAR_LEFT = 6'h08;
	localparam logic [5:0] TYPE_REAR_RIGHT = 6'h09;
	localparam logic [5:0] TYPE_TICK = 6'h0a;
	localparam logic [5:0] TYPE_SPEED = 6'h0b;
	// Message value layout: direction flag on top, magnitude below
	localparam int MEAS_DIR_BIT = 23;
	// Direction vote counter width and its midpoint
	localparam int VOTE_W = 8;
	localparam logic [7:0] VOTE_MID = 8'h80;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hw/tick_pin_counter.sv */
// Tick pin and direction pin counter with direction polarity handling.
// Assumes both pins are asynchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module tick_pin_counter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Pins
	input wire logic tickPulsePin,
	input wire logic directionPin,
	// Settings
	input wire logic tickPinEnable,
	input wire logic dualEdgeCountEnable,
	input wire logic directionPolarityAutoOff,
	input wire logic directionPolaritySelect,
	// Results
	output logic [31:0] tickCount,
	output logic forward,
	output logic polarityUsed
);
	import odo_pkg::*;

	typedef struct packed {
		logic [1:0] tickSync;
		logic [1:0] dirSync;
		logic tickPrev;
		logic [31:0] count;
		logic [VOTE_W-1:0] vote;
		logic forward;
		logic polarity;
	} cnt_s;

	cnt_s s;
	cnt_s next_s;

	// Sync, edge detect, count and direction capture
	always_comb begin
		logic edgeHit;
		logic autoPol;
		logic pol;
		edgeHit = 1'b0;
		autoPol = 1'b0;
		pol = 1'b0;
		next_s = s;
		next_s.tickSync = {s.tickSync[0], tickPulsePin};
		next_s.dirSync = {s.dirSync[0], directionPin};
		next_s.tickPrev = s.tickSync[1];
		if (dualEdgeCountEnable) begin
			edgeHit = s.tickSync[1] ^ s.tickPrev;
		end else begin
			edgeHit = s.tickSync[1] & ~s.tickPrev;
		end
		// Majority level while ticking is taken as forward
		autoPol = s.vote[VOTE_W-1];
		pol = directionPolarityAutoOff ? directionPolaritySelect : autoPol;
		next_s.polarity = pol;
		if (edgeHit && tickPinEnable) begin
			next_s.count = s.count + 32'h1;
			next_s.forward = (s.dirSync[1] == pol);
			if (s.dirSync[1] && s.vote != '1) begin
				next_s.vote = s.vote + 8'h1;
			end else if (!s.dirSync[1] && s.vote != '0) begin
				next_s.vote = s.vote - 8'h1;
			end
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s <= '0;
			s.vote <= VOTE_MID;
			s.forward <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign tickCount = s.count;
	assign forward = s.forward;
	assign polarityUsed = s.polarity;
endmodule
`default_nettype wire

/* hw/odometer_input_frontend.sv */
// Odometer front end: pin ticks, message-borne ticks and speed, time tags.
// Assumes a message parser on core_clk giving start, item and end strobes.
//
// Overview of operation
// - Tick pin counts only when enabled
// - Direction polarity automatic unless manually overridden
// - Dual-edge setting counts both tick edges
// - Type 10 ticks, type 11 speed
// - Message data overrides pin unless disabled
// - Limit one estimates power-of-two rollover
// - Speed alone selects speed unless disabled
// - With ticks, speed select picks type
// - Unset sample rate measured from steady messages
// - Latency zero unless configured
// - Unset tick quantisation auto initialised
// - Unset speed accuracy auto determined; no speed accuracy setting or flag is kept here
// - Unset scale factor estimated at start
// - Merge setting uses combined rear ticks
// - Tag by first byte or time mark
// - First byte time minus latency
// - Time mark flags next message, minus latency
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module odometer_input_frontend #(
	parameter int MS_CYCLES = odo_pkg::CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// AXI4-Lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Pins
	input wire logic tickPulsePin,
	input wire logic directionPin,
	input wire logic externalTimeMarkInput,
	// Measurement message parser
	input wire logic msgStart,
	input wire logic measValid,
	input wire logic [5:0] measType,
	input wire logic [23:0] measData,
	input wire logic msgEnd,
	// Odometer samples to the fusion side
	output logic odoValid,
	output logic odoIsSpeed,
	output logic odoForward,
	output logic [31:0] odoValue,
	output logic [31:0] odoTime,
	output logic quantAuto,
	output logic scaleAuto
);
	import odo_pkg::*;

	typedef struct packed {
		logic awHeld, wHeld;
		logic [7:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic awready, wready, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
		logic [CTRL_W-1:0] ctrl;
		logic [31:0] rollLimit, sampleRate, latency, quantErr, scale, hwPeriod;
		logic [31:0] msDiv, msTime, hwMsCnt, lastHwCount;
		logic [1:0] markSync;
		logic markPrev, markArmed;
		logic [31:0] markTime, firstTime;
		logic inMsg, tickSeen, speedSeen, leftSeen, rightSeen, swSeen;
		logic [23:0] tickVal, speedVal, leftVal, rightVal;
		logic haveAbs;
		logic [31:0] prevAbs, maxSeen;
		logic haveMsg, rateLearned;
		logic [31:0] lastMsgTime, lastInterval, measInterval;
		logic odoValid, odoIsSpeed, odoForward;
		logic [31:0] odoValue, odoTime;
		logic quantAuto, scaleAuto;
	} fe_s;

	fe_s s;
	fe_s next_s;
	logic [31:0] hwCount;
	logic hwForward;
	logic hwPolarity;

	// True for every register offset in the map
	function automatic logic isMapped(input logic [7:0] a);
		return (a <= OFS_CLEAR) && (a[1:0] == 2'h0);
	endfunction

	// Byte-lane merge of a write into a register
	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Smallest power of two above a value
	function automatic logic [31:0] pow2Above(input logic [31:0] v);
		logic [31:0] m;
		m = v;
		for (int i = 1; i < 32; i = i * 2) begin
			m = m | (m >> i);
		end
		return m + 32'h1;
	endfunction

	// Pin counter
	tick_pin_counter pinCounter (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.tickPulsePin(tickPulsePin),
		.directionPin(directionPin),
		.tickPinEnable(s.ctrl[TICK_PIN_ENABLE]),
		.dualEdgeCountEnable(s.ctrl[DUAL_EDGE_COUNT_ENABLE]),
		.directionPolarityAutoOff(s.ctrl[DIRECTION_POLARITY_AUTO_OFF]),
		.directionPolaritySelect(s.ctrl[DIRECTION_POLARITY_SELECT]),
		.tickCount(hwCount),
		.forward(hwForward),
		.polarityUsed(hwPolarity)
	);

	// Whole next-state computation
	always_comb begin
		logic msTick;
		logic markEdge;
		logic tickAny;
		logic useSpeed;
		logic hwActive;
		logic [31:0] raw;
		logic [31:0] modulus;
		logic [31:0] delta;
		logic [31:0] stamp;
		logic [31:0] interval;
		logic [31:0] rd;
		msTick = 1'b0;
		markEdge = 1'b0;
		tickAny = 1'b0;
		useSpeed = 1'b0;
		hwActive = 1'b0;
		raw = '0;
		modulus = '0;
		delta = '0;
		stamp = '0;
		interval = '0;
		rd = '0;
		next_s = s;
		next_s.odoValid = 1'b0;

		// Write address and data, taken in either order
		if (awvalid && s.awready) begin
			next_s.awHeld = 1'b1;
			next_s.awAddr = awaddr;
		end
		if (wvalid && s.wready) begin
			next_s.wHeld = 1'b1;
			next_s.wData = wdata;
			next_s.wStrb = wstrb;
		end
		if (s.awHeld && s.wHeld && !s.bvalid) begin
			unique case (s.awAddr)
				OFS_CTRL: next_s.ctrl = CTRL_W'(mergeBytes(32'(s.ctrl), s.wData, s.wStrb));
				OFS_ROLL: next_s.rollLimit = mergeBytes(s.rollLimit, s.wData, s.wStrb);
				OFS_RATE: next_s.sampleRate = mergeBytes(s.sampleRate, s.wData, s.wStrb);
				OFS_LAT: next_s.latency = mergeBytes(s.latency, s.wData, s.wStrb);
				OFS_QUANT: next_s.quantErr = mergeBytes(s.quantErr, s.wData, s.wStrb);
				OFS_SCALE: next_s.scale = mergeBytes(s.scale, s.wData, s.wStrb);
				OFS_HWPER: next_s.hwPeriod = mergeBytes(s.hwPeriod, s.wData, s.wStrb);
				OFS_CLEAR: begin
					if (s.wStrb[0] && s.wData[0]) begin
						next_s.swSeen = 1'b0;
					end
					if (s.wStrb[0] && s.wData[1]) begin
						next_s.rateLearned = 1'b0;
						next_s.haveMsg = 1'b0;
					end
				end
				default: ;
			endcase
			next_s.bresp = isMapped(s.awAddr) ? RESP_OKAY : RESP_SLVERR;
			next_s.bvalid = 1'b1;
			next_s.awHeld = 1'b0;
			next_s.wHeld = 1'b0;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		next_s.awready = !next_s.awHeld && !next_s.bvalid;
		next_s.wready = !next_s.wHeld && !next_s.bvalid;

		// Read channel, one read at a time
		unique case (araddr)
			OFS_CTRL: rd = 32'(s.ctrl);
			OFS_ROLL: rd = s.rollLimit;
			OFS_RATE: rd = s.sampleRate;
			OFS_LAT: rd = s.latency;
			OFS_QUANT: rd = s.quantErr;
			OFS_SCALE: rd = s.scale;
			OFS_HWPER: rd = s.hwPeriod;
			OFS_STAT: rd = {25'h0, s.markArmed, s.rateLearned, s.scaleAuto, s.quantAuto,
				hwPolarity, s.inMsg, s.swSeen};
			OFS_HWCNT: rd = hwCount;
			OFS_ESTMAX: rd = pow2Above(s.maxSeen);
			OFS_MEASINT: rd = s.measInterval;
			default: rd = '0;
		endcase
		if (arvalid && s.arready) begin
			next_s.rdata = rd;
			next_s.rresp = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			next_s.rvalid = 1'b1;
			next_s.arready = 1'b0;
		end
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end

		// Millisecond time base for all time tags
		msTick = (s.msDiv == 32'(MS_CYCLES - 1));
		next_s.msDiv = msTick ? '0 : s.msDiv + 32'h1;
		if (msTick) begin
			next_s.msTime = s.msTime + 32'h1;
		end

		// Time mark pin: synchronise, catch rising edge, arm next message
		next_s.markSync = {s.markSync[0], externalTimeMarkInput};
		next_s.markPrev = s.markSync[1];
		markEdge = s.markSync[1] && !s.markPrev;
		if (markEdge) begin
			next_s.markTime = s.msTime;
			next_s.markArmed = 1'b1;
		end

		// Message collection
		if (msgStart) begin
			next_s.inMsg = 1'b1;
			next_s.firstTime = s.msTime;
			next_s.tickSeen = 1'b0;
			next_s.speedSeen = 1'b0;
			next_s.leftSeen = 1'b0;
			next_s.rightSeen = 1'b0;
		end
		if (measValid && s.inMsg) begin
			unique case (measType)
				TYPE_TICK: begin
					next_s.tickSeen = 1'b1;
					next_s.tickVal = measData;
				end
				TYPE_SPEED: begin
					next_s.speedSeen = 1'b1;
					next_s.speedVal = measData;
				end
				TYPE_REAR_LEFT: begin
					next_s.leftSeen = 1'b1;
					next_s.leftVal = measData;
				end
				TYPE_REAR_RIGHT: begin
					next_s.rightSeen = 1'b1;
					next_s.rightVal = measData;
				end
				default: ;
			endcase
		end

		// Message end: choose data, convert counts, time tag
		if (msgEnd && s.inMsg) begin
			next_s.inMsg = 1'b0;
			tickAny = s.tickSeen || (s.leftSeen && s.rightSeen);
			// Speed alone picks speed unless auto select is off; otherwise the select setting decides
			useSpeed = s.speedSeen && (s.ctrl[SPEED_INPUT_SELECT] ||
				(!tickAny && !s.ctrl[SPEED_AUTO_SELECT_OFF]));
			if (s.ctrl[REAR_WHEEL_MERGE_ENABLE] && s.leftSeen && s.rightSeen) begin
				raw = 32'(s.leftVal[MEAS_DIR_BIT-1:0]) + 32'(s.rightVal[MEAS_DIR_BIT-1:0]);
			end else begin
				raw = 32'(s.tickVal[MEAS_DIR_BIT-1:0]);
			end
			if (s.rollLimit == 32'h1 && !s.ctrl[ROLLOVER_ESTIMATE_OFF]) begin
				modulus = pow2Above(s.maxSeen);
			end else begin
				modulus = s.rollLimit;
			end
			if (s.rollLimit == '0) begin
				delta = raw;
			end else if (!s.haveAbs) begin
				delta = '0;
			end else if (raw >= s.prevAbs) begin
				delta = raw - s.prevAbs;
			end else begin
				delta = raw + modulus - s.prevAbs;
			end
			// Time mark if armed in that mode, else first byte; less latency
			if (s.ctrl[TIME_MARK_MODE] && s.markArmed) begin
				stamp = s.markTime - s.latency;
				next_s.markArmed = markEdge;
			end else begin
				stamp = s.firstTime - s.latency;
			end
			if (useSpeed || tickAny) begin
				next_s.swSeen = 1'b1;
				next_s.odoValid = 1'b1;
				next_s.odoIsSpeed = useSpeed;
				next_s.odoTime = stamp;
				if (useSpeed) begin
					next_s.odoValue = 32'(s.speedVal[MEAS_DIR_BIT-1:0]);
					next_s.odoForward = !s.speedVal[MEAS_DIR_BIT];
				end else begin
					next_s.odoValue = delta;
					next_s.odoForward = s.ctrl[REAR_WHEEL_MERGE_ENABLE] && s.leftSeen && s.rightSeen ?
						!s.leftVal[MEAS_DIR_BIT] : !s.tickVal[MEAS_DIR_BIT];
				end
			end
			if (tickAny && s.rollLimit != '0) begin
				next_s.haveAbs = 1'b1;
				next_s.prevAbs = raw;
				if (raw > s.maxSeen) begin
					next_s.maxSeen = raw;
				end
			end
			// Learn the message interval when no rate is configured
			if (s.sampleRate == '0 && (useSpeed || tickAny)) begin
				interval = s.firstTime - s.lastMsgTime;
				if (s.haveMsg && interval == s.lastInterval && interval != '0) begin
					next_s.measInterval = interval;
					next_s.rateLearned = 1'b1;
				end
				next_s.lastInterval = interval;
				next_s.lastMsgTime = s.firstTime;
				next_s.haveMsg = 1'b1;
			end
		end

		// Pin samples, dropped while message data holds priority
		hwActive = s.ctrl[TICK_PIN_ENABLE] && !(s.swSeen && !s.ctrl[MESSAGE_SOURCE_AUTO_OFF]);
		if (msTick) begin
			next_s.hwMsCnt = (s.hwMsCnt + 32'h1 >= s.hwPeriod) ? '0 : s.hwMsCnt + 32'h1;
			if (s.hwMsCnt + 32'h1 >= s.hwPeriod && hwActive && !next_s.odoValid) begin
				next_s.odoValid = 1'b1;
				next_s.odoIsSpeed = 1'b0;
				next_s.odoValue = hwCount - s.lastHwCount;
				next_s.odoForward = hwForward;
				next_s.odoTime = s.msTime - s.latency;
				next_s.lastHwCount = hwCount;
			end
		end

		// Unset settings fall back to automatic initialisation
		next_s.quantAuto = (next_s.quantErr == '0);
		next_s.scaleAuto = (next_s.scale == '0);
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s <= '0;
			s.ctrl <= CTRL_RST;
			s.hwPeriod <= HWPER_RST;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.odoForward <= 1'b1;
			s.quantAuto <= 1'b1;
			s.scaleAuto <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign awready = s.awready;
	assign wready = s.wready;
	assign bresp = s.bresp;
	assign bvalid = s.bvalid;
	assign arready = s.arready;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign rvalid = s.rvalid;
	assign odoValid = s.odoValid;
	assign odoIsSpeed = s.odoIsSpeed;
	assign odoForward = s.odoForward;
	assign odoValue = s.odoValue;
	assign odoTime = s.odoTime;
	assign quantAuto = s.quantAuto;
	assign scaleAuto = s.scaleAuto;
endmodule
`default_nettype wire

/* tb/odo_checker.sv */
// Assertion checker on the ports of the odometer front end.
// Bound to every front end instance; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module odo_checker (
	// Clock and reset
	input wire logic core_clk, sys_rst,
	// Register bus
	input wire logic awvalid, awready, wvalid, wready, bvalid, bready,
	input wire logic arvalid, arready, rvalid, rready,
	input wire logic [7:0] araddr,
	input wire logic [1:0] bresp, rresp,
	input wire logic [31:0] rdata,
	// Samples
	input wire logic odoValid, odoIsSpeed, odoForward, quantAuto, scaleAuto,
	input wire logic [31:0] odoValue, odoTime
);
	import odo_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Write answer two cycles after both halves are taken
	a_write_answer: assert property (awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
		else $error("write answer not on time");
	// Write response holds until accepted
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	// Read answer right after the address is taken
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer not on time");
	// Read data holds until accepted
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	// Read channel frees after the handshake
	a_read_free: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read channel not freed");
	// Unmapped or misaligned reads give zero and an error
	a_read_refuse: assert property (arvalid && arready && (araddr > OFS_CLEAR || araddr[1:0] != 2'h0)
		|=> rresp == RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	// Reset leaves no sample and both auto flags set
	a_reset_state: assert property (disable iff (1'b0) sys_rst |=> quantAuto && scaleAuto && !odoValid)
		else $error("reset state wrong");
	// Sample fields change only with a sample strobe
	a_sample_hold: assert property (!odoValid |-> $stable({odoValue, odoTime, odoIsSpeed, odoForward}))
		else $error("sample changed without strobe");
	// Sample strobe lasts one cycle
	a_sample_pulse: assert property (odoValid |=> !odoValid)
		else $error("sample strobe too long");
endmodule
bind odometer_input_frontend odo_checker chk_u (
	.core_clk(core_clk), .sys_rst(sys_rst),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
	.rvalid(rvalid), .rready(rready), .araddr(araddr), .bresp(bresp), .rresp(rresp), .rdata(rdata),
	.odoValid(odoValid), .odoIsSpeed(odoIsSpeed), .odoForward(odoForward),
	.quantAuto(quantAuto), .scaleAuto(scaleAuto), .odoValue(odoValue), .odoTime(odoTime)
);
`default_nettype wire

/* tb/odo_partner.sv */
// Behavioural wheel tick sensor and message preprocessor.
// Drives the pins and the parser strobes of the front end.
`timescale 1ns/10ps
`default_nettype none
module odo_partner (
	// Clock
	input wire logic core_clk,
	// Pins
	output logic tickPulsePin, directionPin, externalTimeMarkInput,
	// Message strobes
	output logic msgStart, measValid, msgEnd,
	output logic [5:0] measType,
	output logic [23:0] measData
);
	// Idle levels
	initial begin
		tickPulsePin = 1'b0;
		directionPin = 1'b1;
		externalTimeMarkInput = 1'b0;
		msgStart = 1'b0;
		measValid = 1'b0;
		msgEnd = 1'b0;
		measType = 6'h00;
		measData = 24'h5a5a5a;
	end
	// Half duty square wave
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge core_clk);
			tickPulsePin <= 1'b1;
			repeat (4) @(posedge core_clk);
			tickPulsePin <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask
	// Time mark pulse at measurement time
	task automatic mark();
		@(posedge core_clk);
		externalTimeMarkInput <= 1'b1;
		repeat (4) @(posedge core_clk);
		externalTimeMarkInput <= 1'b0;
	endtask
	// One message of one or two items; second type zero means none
	task automatic msg(input logic [5:0] t0, input logic [23:0] d0, input logic [5:0] t1, input logic [23:0] d1);
		@(posedge core_clk);
		msgStart <= 1'b1;
		@(posedge core_clk);
		msgStart <= 1'b0;
		measValid <= 1'b1;
		measType <= t0;
		measData <= d0;
		if (t1 != 6'h00) begin
			@(posedge core_clk);
			measType <= t1;
			measData <= d1;
		end
		@(posedge core_clk);
		measValid <= 1'b0;
		measData <= ~measData;
		msgEnd <= 1'b1;
		@(posedge core_clk);
		msgEnd <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* tb/tb_odometer_input_frontend.sv */
// Self-checking bench for the odometer front end: bus, messages, pins.
// Uses the partner model for pins and message strobes.
`timescale 1ns/10ps
`default_nettype none
module tb_odometer_input_frontend;
	import odo_pkg::*;
	localparam int MSC = 40;
	logic core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, odoValid, odoIsSpeed, odoForward, quantAuto, scaleAuto;
	logic tickPulsePin, directionPin, externalTimeMarkInput, msgStart, measValid, msgEnd;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, odoValue, odoTime, rd, c0;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [5:0] measType;
	logic [23:0] measData;
	int err_total, cmp_count, cyc, tm, n;

	odometer_input_frontend #(.MS_CYCLES(MSC)) dut_u (.*);
	odo_partner partner_u (.*);

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Cycle count and hang guard
	always @(posedge core_clk) begin
		if (!sys_rst)
			cyc <= cyc + 1;
		if (cyc > 30000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rd = rdata;
		rready <= 1'b0;
		chk(rd & m, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	task automatic wait_mid();
		@(posedge core_clk);
		while (cyc % MSC != MSC / 2)
			@(posedge core_clk);
	endtask
	// Message then its sample: {isSpeed, forward, value}, time when lat not negative
	task automatic msg_chk(input logic [5:0] t0, input logic [23:0] d0, input logic [5:0] t1,
		input logic [23:0] d1, input logic [33:0] e, input int lat);
		int ms;
		wait_mid();
		ms = cyc / MSC - lat;
		partner_u.msg(t0, d0, t1, d1);
		repeat (3) begin
			@(posedge core_clk);
			if (odoValid === 1'b1)
				break;
		end
		chk({31'h0, odoValid}, 32'h1);
		chk({30'h0, odoIsSpeed, odoForward}, {30'h0, e[33:32]});
		chk(odoValue, e[31:0]);
		if (lat >= 0)
			chk(odoTime, 32'(ms));
	endtask
	task automatic msg1(input logic [5:0] t, input logic [23:0] d, input logic [33:0] e, input int lat);
		msg_chk(t, d, 6'h0, 24'h0, e, lat);
	endtask
	task automatic done_test(input string s);
		$display("test %s done", s);
	endtask

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd_chk(OFS_CTRL, '1, {22'h0, CTRL_RST}, RESP_OKAY);
		rd_chk(OFS_HWPER, '1, HWPER_RST, RESP_OKAY);
		rd_chk(OFS_LAT, '1, 32'h0, RESP_OKAY);
		rd_chk(8'h30, '1, 32'h0, RESP_SLVERR);
		wr(8'h41, 32'h1, RESP_SLVERR);
		chk({30'h0, quantAuto, scaleAuto}, 32'h3);
		done_test("reset");
		wr(OFS_ROLL, 32'h1, RESP_OKAY);
		msg1(TYPE_TICK, 24'd500, {2'b01, 32'd0}, 0);
		msg1(TYPE_TICK, 24'd1000, {2'b01, 32'd500}, 0);
		msg1(TYPE_TICK, 24'd10, {2'b01, 32'd34}, 0);
		rd_chk(OFS_MEASINT, '1, 32'h1, RESP_OKAY);
		wr(OFS_CTRL, 32'h1 << ROLLOVER_ESTIMATE_OFF, RESP_OKAY);
		wr(OFS_ROLL, 32'd1000, RESP_OKAY);
		msg1(TYPE_TICK, 24'd990, {2'b01, 32'd980}, 0);
		msg1(TYPE_TICK, 24'd5, {2'b01, 32'd15}, 0);
		done_test("rollover");
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		wr(OFS_ROLL, 32'h0, RESP_OKAY);
		msg1(TYPE_TICK, 24'h800005, {2'b00, 32'd5}, 0);
		msg1(TYPE_SPEED, 24'h000007, {2'b11, 32'd7}, 0);
		msg_chk(TYPE_TICK, 24'd5, TYPE_SPEED, 24'd9, {2'b01, 32'd5}, 0);
		wr(OFS_CTRL, 32'h1 << SPEED_INPUT_SELECT, RESP_OKAY);
		msg_chk(TYPE_TICK, 24'd5, TYPE_SPEED, 24'd9, {2'b11, 32'd9}, 0);
		wr(OFS_LAT, 32'h2, RESP_OKAY);
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		msg1(TYPE_TICK, 24'd3, {2'b01, 32'd3}, 2);
		wr(OFS_CTRL, 32'h1 << REAR_WHEEL_MERGE_ENABLE, RESP_OKAY);
		msg_chk(TYPE_REAR_LEFT, 24'd3, TYPE_REAR_RIGHT, 24'd4, {2'b01, 32'd7}, 2);
		done_test("messages");
		wr(OFS_CTRL, 32'h1 << TIME_MARK_MODE, RESP_OKAY);
		wait_mid();
		tm = cyc / MSC - 2;
		partner_u.mark();
		repeat (2 * MSC) @(posedge core_clk);
		msg1(TYPE_TICK, 24'd4, {2'b01, 32'd4}, -1);
		chk(odoTime, 32'(tm));
		msg1(TYPE_TICK, 24'd6, {2'b01, 32'd6}, 2);
		done_test("time tags");
		wr(OFS_QUANT, 32'h5, RESP_OKAY);
		wr(OFS_SCALE, 32'h5, RESP_OKAY);
		chk({30'h0, quantAuto, scaleAuto}, 32'h0);
		for (int s = 0; s < 2; s++) begin
			wr(OFS_CTRL, (32'h1 << DIRECTION_POLARITY_AUTO_OFF) | (32'(s) << DIRECTION_POLARITY_SELECT), RESP_OKAY);
			rd_chk(OFS_STAT, 32'h4, 32'(s) << 2, RESP_OKAY);
		end
		done_test("settings");
		for (int m = 0; m < 3; m++) begin
			wr(OFS_CTRL, (32'(m > 0) << TICK_PIN_ENABLE) | (32'(m == 2) << DUAL_EDGE_COUNT_ENABLE) | 32'h10, RESP_OKAY);
			rd_chk(OFS_HWCNT, 32'h0, 32'h0, RESP_OKAY);
			c0 = rd;
			partner_u.ticks(5);
			repeat (8) @(posedge core_clk);
			rd_chk(OFS_HWCNT, 32'h0, 32'h0, RESP_OKAY);
			chk(rd - c0, 32'(5 * m));
		end
		wr(OFS_HWPER, 32'h1, RESP_OKAY);
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			if (k == 1)
				wr(OFS_CLEAR, 32'h1, RESP_OKAY);
			n = 0;
			repeat (3 * MSC) begin
				@(posedge core_clk);
				if (odoValid === 1'b1) begin
					n++;
					chk({31'h0, odoForward}, 32'h1);
				end
			end
			chk(32'(n > 0), 32'(k));
		end
		done_test("pins");
		report_and_stop();
	end
endmodule
`default_nettype wire
